// ==== clc_pkg.sv ====
`default_nettype none
package clc_pkg;
	// Timing, all in nanoseconds, and derived cycle counts (all divide exactly)
	localparam int CLK_NS      = 8;
	localparam int T_LONG_NS   = 1_640_000;
	localparam int T_SHORT_NS  = 40_000;
	localparam int T_DATA_NS   = 46_000;
	localparam int T_BLINK_NS  = 204_800_000;
	localparam int LONG_CYC    = T_LONG_NS / CLK_NS;
	localparam int SHORT_CYC   = T_SHORT_NS / CLK_NS;
	localparam int DATA_CYC    = T_DATA_NS / CLK_NS;
	localparam int BLINK_CYC   = T_BLINK_NS / CLK_NS;
	localparam int BUSY_W      = 26;
	// Memory sizes and addressing
	localparam int CHAR_DEPTH  = 128;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [7:0] SPACE_CODE   = 8'h20;
	localparam logic [6:0] ONE_LAST     = 7'h4F;
	localparam logic [6:0] L1_LAST      = 7'h27;
	localparam logic [6:0] L2_FIRST     = 7'h40;
	localparam logic [6:0] L2_LAST      = 7'h67;
	localparam logic [6:0] SHIFT_MOD_1L = 7'h50;
	localparam logic [6:0] SHIFT_MOD_2L = 7'h28;
	// Font rows and row drive masks
	localparam logic [3:0]  CUR_ROW_SHORT = 4'h7;
	localparam logic [3:0]  CUR_ROW_TALL  = 4'hA;
	localparam logic [15:0] ROWS_SHORT    = 16'h00FF;
	localparam logic [15:0] ROWS_TALL     = 16'h07FF;
	localparam logic [15:0] ROWS_TWO      = 16'hFFFF;
	// Avalon register byte offsets and fields
	localparam logic [3:0] AV_STATUS    = 4'h0;
	localparam logic [3:0] AV_MODE      = 4'h4;
	localparam logic [3:0] AV_CTRL      = 4'h8;
	localparam int         CTRL_EN_BIT  = 0;
	localparam logic       CTRL_EN_RST  = 1'b1;
	// Complete state of the engine
	typedef struct packed {
		logic                         e_prev;     // Previous strobe level
		logic                         acc_rs;     // Space select caught at strobe rise
		logic                         acc_rd;     // Direction caught at strobe rise
		logic                         nib_phase;  // Second nibble expected
		logic [3:0]                   nib_hi;     // Held high nibble
		logic [7:0]                   dout;       // Host read data
		logic                         doe;        // Host bus drive enable
		logic                         busy;       // Occupied flag
		logic [BUSY_W-1:0]            busy_cnt;   // Remaining execution cycles
		logic                         clr_run;    // Space fill in progress
		logic [6:0]                   clr_idx;    // Space fill address
		logic [6:0]                   ptr;        // Shared RAM pointer
		logic                         glyph_sel;  // Pointer aims at glyph memory
		logic [7:0]                   dlatch;     // Read prefetch latch
		logic                         dir_up;     // Entry direction
		logic                         shift_en;   // Entry display shift
		logic                         disp_on;    // Display enable
		logic                         cur_on;     // Cursor enable
		logic                         blink_on;   // Blink enable
		logic                         width8;     // Bus width bit
		logic                         two_line;   // Two line mode
		logic                         tall;       // Tall font
		logic [6:0]                   shift_off;  // Display shift offset
		logic [15:0]                  row_mask;   // Driven rows
		logic [3:0]                   cur_row;    // Cursor row index
		logic [BUSY_W-1:0]            blink_cnt;  // Blink half period count
		logic                         blink_ph;   // Blink phase
		logic                         blink_dim;  // Blanks the cursor character
		logic [7:0]                   scan_code;  // Refresh character code
		logic [4:0]                   glyph_row;  // Refresh glyph row dots
		logic                         glyph_hit;  // Refresh code is a user glyph
		logic                         av_wait;    // Avalon waitrequest
		logic [31:0]                  av_rdata;   // Avalon read data
		logic                         port_en;    // Host port enable
		logic [CHAR_DEPTH-1:0][7:0]   cmem;       // Character code memory
		logic [GLYPH_DEPTH-1:0][7:0]  gmem;       // User glyph memory
	} clc_state_s;
endpackage
`default_nettype wire

// ==== clc_engine.sv ====
`default_nettype none
module clc_engine
	import clc_pkg::*;
#(
	parameter int LONG_CYCLES  = LONG_CYC,   // Clear and home time
	parameter int SHORT_CYCLES = SHORT_CYC,  // Ordinary command time
	parameter int DATA_CYCLES  = DATA_CYC,   // Data transfer time
	parameter int BLINK_CYCLES = BLINK_CYC   // Blink half period
) (
	input  wire logic        clk,                // 125 MHz clock
	input  wire logic        rst_n,              // Async reset, active low
	input  wire logic        reg_space_select,   // High selects data space
	input  wire logic        host_read,          // High for a read access
	input  wire logic        host_strobe,        // Access enable strobe
	input  wire logic [7:0]  host_bus_lines_in,  // Bus lines from host
	output logic      [7:0]  host_bus_lines_out, // Bus lines to host
	output logic      [7:0]  host_bus_lines_oe,  // Drive enables
	input  wire logic [6:0]  scan_addr,          // Refresh character address
	input  wire logic [7:0]  scan_glyph_code,    // Refresh code for glyph lookup
	input  wire logic [3:0]  scan_row,           // Refresh glyph row
	output logic      [7:0]  scan_code_q,        // Refresh character code
	output logic      [4:0]  glyph_row_q,        // User glyph row dots
	output logic             glyph_hit_q,        // Code selects user glyph
	output logic      [15:0] row_drive_mask_q,   // Rows carrying drive waveforms
	output logic      [6:0]  cursor_addr_q,      // Cursor digit address
	output logic      [3:0]  cursor_row_q,       // Cursor row index
	output logic             disp_on_q,          // Display enable
	output logic             cursor_on_q,        // Cursor enable
	output logic             blink_dim_q,        // Cursor character blanked now
	output logic      [6:0]  shift_off_q,        // Display shift offset
	output logic             occupied_flag_q,    // Busy flag
	input  wire logic [3:0]  avs_address,        // Avalon byte address
	input  wire logic        avs_read,           // Avalon read
	input  wire logic        avs_write,          // Avalon write
	input  wire logic [3:0]  avs_byteenable,     // Avalon byte enables
	input  wire logic [31:0] avs_writedata,      // Avalon write data
	output logic      [31:0] avs_readdata,       // Avalon read data
	output logic             avs_waitrequest     // Avalon waitrequest
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and state

	logic [1:0]  rsync_q;    // Reset release synchroniser
	logic        rst_sync_n; // Released reset
	clc_state_s  q;          // Present state
	clc_state_s  d;          // Next state
	logic        wr_fall;    // Host write strobe ends
	logic        commit_go;  // A whole byte is taken
	logic        commit_rs;  // Space of the taken byte
	logic [7:0]  commit_b;   // Taken byte
	logic        host_rise;  // Host strobe rises

	// Two-flop release of the asynchronous reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsync_q <= 2'b00;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rsync_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Pointer step with line wrap
	function automatic logic [6:0] ptr_step(input logic [6:0] p, input logic up,
		input logic glyph, input logic two);
		logic [6:0] r;
		r = p;
		if (glyph) begin
			r = up ? {1'b0, 6'(p[5:0] + 6'h01)} : {1'b0, 6'(p[5:0] - 6'h01)};
		end else if (two) begin
			if (up) begin
				r = (p == L1_LAST) ? L2_FIRST : ((p == L2_LAST) ? 7'h00 : 7'(p + 7'h01));
			end else begin
				r = (p == 7'h00) ? L2_LAST : ((p == L2_FIRST) ? L1_LAST : 7'(p - 7'h01));
			end
		end else begin
			if (up) begin
				r = (p == ONE_LAST) ? 7'h00 : 7'(p + 7'h01);
			end else begin
				r = (p == 7'h00) ? ONE_LAST : 7'(p - 7'h01);
			end
		end
		return r;
	endfunction

	// Display shift offset step; left shows later addresses
	function automatic logic [6:0] off_step(input logic [6:0] o, input logic left,
		input logic two);
		logic [6:0] m;
		m = two ? SHIFT_MOD_2L : SHIFT_MOD_1L;
		if (left) begin
			return (o >= 7'(m - 7'h01)) ? 7'h00 : 7'(o + 7'h01);
		end
		return (o == 7'h00) ? 7'(m - 7'h01) : 7'(o - 7'h01);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	// All behaviour of the engine
	always_comb begin
		logic        rd_fall;
		logic [7:0]  v;
		logic [6:0]  np;
		logic [5:0]  gaddr;
		rd_fall   = 1'b0;
		v         = 8'h00;
		np        = 7'h00;
		gaddr     = 6'h00;
		d         = q;
		commit_go = 1'b0;
		commit_rs = 1'b0;
		commit_b  = 8'h00;
		host_rise = q.port_en & host_strobe & ~q.e_prev;
		wr_fall   = q.port_en & ~host_strobe & q.e_prev & ~q.acc_rd;
		rd_fall   = q.port_en & ~host_strobe & q.e_prev & q.acc_rd;
		d.e_prev  = host_strobe;

		// Refresh port reads only; host writes never stall it
		d.scan_code = q.cmem[scan_addr];
		gaddr = q.tall ? {scan_glyph_code[2:1], scan_row}
			: {scan_glyph_code[2:0], scan_row[2:0]};
		d.glyph_hit = (scan_glyph_code[7:4] == 4'h0);
		d.glyph_row = (scan_row > q.cur_row) ? 5'h00 : q.gmem[gaddr][4:0];

		// Blink phase runs free; cursor may show too
		if (q.blink_cnt == '0) begin
			d.blink_cnt = BUSY_W'(BLINK_CYCLES - 1);
			d.blink_ph  = ~q.blink_ph;
		end else begin
			d.blink_cnt = q.blink_cnt - 1'b1;
		end
		d.blink_dim = q.blink_on & q.blink_ph;

		// Execution timer and space fill
		if (q.busy_cnt != '0) begin
			d.busy_cnt = q.busy_cnt - 1'b1;
		end
		if (q.clr_run) begin
			d.cmem[q.clr_idx] = SPACE_CODE;
			d.clr_idx = 7'(q.clr_idx + 7'h01);
			d.clr_run = (q.clr_idx != 7'h7F);
		end

		// Strobe rise: catch access kind and present read data
		if (host_rise) begin
			d.acc_rs = reg_space_select;
			d.acc_rd = host_read;
			if (host_read) begin
				v = reg_space_select ? q.dlatch : {q.busy, q.ptr};
				d.dout = (q.width8 || !q.nib_phase) ? v : {v[3:0], 4'h0};
				d.doe  = 1'b1;
			end
		end

		// Strobe fall: release bus, pair nibbles, commit
		if (rd_fall || wr_fall) begin
			d.doe = 1'b0;
			if (!q.width8) begin
				d.nib_phase = ~q.nib_phase;
			end
		end
		if (wr_fall) begin
			if (!q.width8 && !q.nib_phase) begin
				d.nib_hi = host_bus_lines_in[7:4];
			end else if (!q.busy) begin
				commit_go = 1'b1;
				commit_rs = q.acc_rs;
				commit_b  = q.width8 ? host_bus_lines_in
					: {q.nib_hi, host_bus_lines_in[7:4]};
			end
		end

		// Data read completes: step pointer and prefetch the next byte
		if (rd_fall && q.acc_rs && !q.busy && (q.width8 || q.nib_phase)) begin
			np = ptr_step(q.ptr, q.dir_up, q.glyph_sel, q.two_line);
			d.ptr = np;
			d.dlatch = q.glyph_sel ? q.gmem[np[5:0]] : q.cmem[np];
			d.busy_cnt = BUSY_W'(DATA_CYCLES);
		end

		// Command and data decode
		if (commit_go && commit_rs) begin
			// Data write: one location only, latch left stale
			if (q.glyph_sel) begin
				d.gmem[q.ptr[5:0]] = commit_b;
			end else begin
				d.cmem[q.ptr] = commit_b;
				if (q.shift_en) begin
					d.shift_off = off_step(q.shift_off, q.dir_up, q.two_line);
				end
			end
			d.ptr = ptr_step(q.ptr, q.dir_up, q.glyph_sel, q.two_line);
			d.busy_cnt = BUSY_W'(DATA_CYCLES);
		end else if (commit_go) begin
			d.busy_cnt = BUSY_W'(SHORT_CYCLES);
			casez (commit_b)
				8'b1???????: begin                                            // Character address set
					d.ptr = commit_b[6:0];
					d.glyph_sel = 1'b0;
					d.dlatch = q.cmem[commit_b[6:0]];
				end
				8'b01??????: begin                                            // Glyph address set
					d.ptr = {1'b0, commit_b[5:0]};
					d.glyph_sel = 1'b1;
					d.dlatch = q.gmem[commit_b[5:0]];
				end
				8'b001?????: begin                                            // Function set
					d.width8   = commit_b[4];
					d.two_line = commit_b[3];
					d.tall     = commit_b[2] & ~commit_b[3];
					d.row_mask = commit_b[3] ? ROWS_TWO
						: (commit_b[2] ? ROWS_TALL : ROWS_SHORT);
					d.cur_row  = (commit_b[2] & ~commit_b[3]) ? CUR_ROW_TALL
						: CUR_ROW_SHORT;
					d.nib_phase = 1'b0;
				end
				8'b0001????: begin                                            // Cursor or display shift
					if (commit_b[3]) begin
						d.shift_off = off_step(q.shift_off, ~commit_b[2],
							q.two_line);
					end else begin
						np = ptr_step(q.ptr, commit_b[2], q.glyph_sel,
							q.two_line);
						d.ptr = np;
						d.dlatch = q.glyph_sel ? q.gmem[np[5:0]] : q.cmem[np];
					end
				end
				8'b00001???: begin                                            // On/off control
					d.disp_on  = commit_b[2];
					d.cur_on   = commit_b[1];
					d.blink_on = commit_b[0];
				end
				8'b000001??: begin                                            // Entry mode
					d.dir_up   = commit_b[1];
					d.shift_en = commit_b[0];
				end
				8'b0000001?: begin                                            // Return home
					d.ptr = 7'h00;
					d.glyph_sel = 1'b0;
					d.shift_off = 7'h00;
					d.busy_cnt = BUSY_W'(LONG_CYCLES);
				end
				8'b00000001: begin                                            // Clear display
					d.ptr = 7'h00;
					d.glyph_sel = 1'b0;
					d.shift_off = 7'h00;
					d.dir_up = 1'b0;
					d.clr_run = 1'b1;
					d.clr_idx = 7'h00;
					d.busy_cnt = BUSY_W'(LONG_CYCLES);
				end
				default: begin                                                // Test code: no effect
					d.busy_cnt = '0;
				end
			endcase
		end
		d.busy = (d.busy_cnt != '0) | d.clr_run;

		// Avalon slave: read data prepared, write done in the answer cycle
		d.av_wait = 1'b1;
		if ((avs_read || avs_write) && q.av_wait) begin
			d.av_wait = 1'b0;
			case (avs_address)
				AV_STATUS: d.av_rdata = {22'h0, q.clr_run, q.glyph_sel, q.busy, q.ptr};
				AV_MODE:   d.av_rdata = {17'h0, q.shift_off, q.disp_on, q.cur_on,
					q.blink_on, q.dir_up, q.shift_en, q.width8, q.two_line, q.tall};
				AV_CTRL:   d.av_rdata = {31'h0, q.port_en};
				default:   d.av_rdata = 32'h0;
			endcase
		end else if (avs_write && !q.av_wait && avs_address == AV_CTRL
			&& avs_byteenable[0]) begin
			d.port_en = avs_writedata[CTRL_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// Power-on values run the space fill with defaults already loaded
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			q           <= '0;
			q.busy      <= 1'b1;
			q.busy_cnt  <= BUSY_W'(LONG_CYCLES);
			q.clr_run   <= 1'b1;
			q.dir_up    <= 1'b1;
			q.width8    <= 1'b1;
			q.row_mask  <= ROWS_SHORT;
			q.cur_row   <= CUR_ROW_SHORT;
			q.av_wait   <= 1'b1;
			q.port_en   <= CTRL_EN_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state
	assign host_bus_lines_out = q.dout;
	assign host_bus_lines_oe  = {8{q.doe}};
	assign scan_code_q        = q.scan_code;
	assign glyph_row_q        = q.glyph_row;
	assign glyph_hit_q        = q.glyph_hit;
	assign row_drive_mask_q   = q.row_mask;
	assign cursor_addr_q      = q.ptr;
	assign cursor_row_q       = q.cur_row;
	assign disp_on_q          = q.disp_on;
	assign cursor_on_q        = q.cur_on;
	assign blink_dim_q        = q.blink_dim;
	assign shift_off_q        = q.shift_off;
	assign occupied_flag_q    = q.busy;
	assign avs_readdata       = q.av_rdata;
	assign avs_waitrequest    = q.av_wait;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_cmd(logic [7:0] c);
		commit_go && !commit_rs && commit_b == c;
	endsequence
	sequence s_data_wr;
		commit_go && commit_rs;
	endsequence

	property p_clear_fills;
		q.clr_run |=> q.cmem[$past(q.clr_idx)] == SPACE_CODE && occupied_flag_q;
	endproperty
	a_clear_fills: assert property (p_clear_fills) else $error("space fill missed");
	property p_cmd_busy;
		commit_go && (commit_rs || commit_b != 8'h00) |=> occupied_flag_q;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy) else $error("not occupied after commit");
	property p_ignore_busy;
		wr_fall && q.busy |-> !commit_go;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("write taken while busy");
	property p_status_read;
		host_rise && host_read && !reg_space_select && q.width8
			|=> host_bus_lines_out == {$past(q.busy), $past(q.ptr)} && host_bus_lines_oe[7];
	endproperty
	a_status_read: assert property (p_status_read) else $error("bad status byte");
	property p_row_mask;
		row_drive_mask_q == (q.two_line ? ROWS_TWO : (q.tall ? ROWS_TALL : ROWS_SHORT));
	endproperty
	a_row_mask: assert property (p_row_mask) else $error("row mask wrong");
	property p_no_tall_two;
		q.two_line |-> !q.tall;
	endproperty
	a_no_tall_two: assert property (p_no_tall_two) else $error("tall font in two lines");
	property p_cursor_row;
		cursor_row_q == (q.tall ? CUR_ROW_TALL : CUR_ROW_SHORT);
	endproperty
	a_cursor_row: assert property (p_cursor_row) else $error("cursor row wrong");
	property p_clear_home;
		s_cmd(8'h01) |=> q.ptr == 7'h00 && !q.dir_up && q.shift_en == $past(q.shift_en);
	endproperty
	a_clear_home: assert property (p_clear_home) else $error("clear did not home");
	property p_first_nibble;
		wr_fall && !q.width8 && !q.nib_phase |-> !commit_go ##1 q.nib_phase;
	endproperty
	a_first_nibble: assert property (p_first_nibble) else $error("nibble committed early");
	property p_write_step;
		s_data_wr and (q.dir_up && !q.glyph_sel && !q.two_line && q.ptr != ONE_LAST)
			|=> q.ptr == 7'($past(q.ptr) + 7'h01) && $stable(q.dlatch);
	endproperty
	a_write_step: assert property (p_write_step) else $error("pointer step wrong");
	property p_avs_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_avs_answer: assert property (p_avs_answer) else $error("avalon answer timing");

endmodule
`default_nettype wire

// ==== clc_host.sv ====
`default_nettype none
module clc_host (
	input  wire logic       clk,   // Clock
	output logic            rs,    // Space select
	output logic            rd,    // Read access
	output logic            stb,   // Strobe
	output logic      [7:0] lines, // Wire level seen by engine
	input  wire logic [7:0] dout,  // Engine data
	input  wire logic [7:0] oe     // Engine enables
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv = 8'h00; // Host data
	logic       den = 1'b0;  // Host drives lines
	// Released lines float high on the pull-ups
	assign lines = oe[7] ? dout : (den ? drv : 8'hFF);
	initial begin
		rs = 1'b0;
		rd = 1'b0;
		stb = 1'b0;
	end
	// One strobe; a byte in four-bit width is two calls, high nibble first
	task automatic xfer(input logic s, input logic r, input logic [7:0] d,
		output logic [7:0] q);
		rs <= s;
		rd <= r;
		stb <= 1'b1;
		drv <= d;
		den <= !r;
		@(posedge clk);
		@(posedge clk);
		q = lines;
		stb <= 1'b0;
		@(posedge clk);
		den <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== char_lcd_command_engine_test.sv ====
`default_nettype none
module char_lcd_command_engine_test import clc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;  // Clock
	logic        rst_n = 1'b0; // Reset
	logic        rs, rd, stb, occ, av_wt;
	logic [7:0]  lines, dout, oe;
	logic [18:0] scan = 19'h0; // Refresh stimulus
	logic [3:0]  av_a = 4'h0;
	logic        av_r = 1'b0;
	logic        av_w = 1'b0;
	logic [31:0] av_d = 32'h0;
	logic [31:0] av_q;
	logic        nib = 1'b0;   // Four-bit width in use
	logic [15:0] mask;
	logic [6:0]  cadr;
	logic [3:0]  crow;
	logic [3:0]  av_be = 4'hF;   // Avalon byte enables
	logic [18:0] scan_p = 19'h0; // Refresh stimulus one edge ago
	logic        mon = 1'b0;     // Glyph watch armed
	logic        spc = 1'b0;     // Whole character memory holds spaces
	logic [7:0]  scode;
	logic [4:0]  grow;
	logic        ghit, don, con, bdim;
	logic [6:0]  shoff;
	int          seed = 44451;
	int          num_errors = 0;
	int          compares = 0;
	always #4 clk = ~clk;
	always @(posedge clk) scan <= 19'($random(seed));
	clc_host i_host (.clk(clk), .rs(rs), .rd(rd), .stb(stb), .lines(lines), .dout(dout), .oe(oe));
	clc_engine #(.LONG_CYCLES(300), .SHORT_CYCLES(20), .DATA_CYCLES(25), .BLINK_CYCLES(16)) i_dut (
		.clk(clk), .rst_n(rst_n), .reg_space_select(rs), .host_read(rd), .host_strobe(stb),
		.host_bus_lines_in(lines), .host_bus_lines_out(dout), .host_bus_lines_oe(oe),
		.scan_addr(scan[6:0]), .scan_glyph_code(scan[14:7]), .scan_row(scan[18:15]),
		.scan_code_q(scode), .glyph_row_q(grow), .glyph_hit_q(ghit), .row_drive_mask_q(mask),
		.cursor_addr_q(cadr), .cursor_row_q(crow), .disp_on_q(don), .cursor_on_q(con),
		.blink_dim_q(bdim), .shift_off_q(shoff), .occupied_flag_q(occ), .avs_address(av_a),
		.avs_read(av_r), .avs_write(av_w), .avs_byteenable(av_be), .avs_writedata(av_d),
		.avs_readdata(av_q), .avs_waitrequest(av_wt));
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Refresh watch; outputs trail the stimulus by one edge
	always @(posedge clk) begin
		scan_p <= scan;
		if (mon) begin
			chk("glyph hit", scan_p[14:11] == 4'h0, ghit);
			if (scan_p[18:15] > 4'hA)
				chk("spare row", 0, grow);
			if ((scan_p[14:7] & 8'hF6) == 8'h00 && scan_p[18:15] < 4'h8)
				chk("glyph dots", 5'h1F, grow);
		end
		if (spc)
			chk("refresh code", SPACE_CODE, scode);
	end
	// Avalon access, held until waitrequest is sampled low
	task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		av_a <= a;
		av_w <= w;
		av_r <= !w;
		av_d <= d;
		do begin
			@(posedge clk);
			n++;
		end while (av_wt !== 1'b0 && n < 50);
		q = av_q;
		av_w <= 1'b0;
		av_r <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			finish_test();
		end
	endtask
	// Byte transfer, split into nibbles in four-bit width
	task automatic hx(input logic s, input logic r, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] t;
		if (nib) begin
			i_host.xfer(s, r, {d[7:4], 4'h0}, t);
			i_host.xfer(s, r, {d[3:0], 4'h0}, q);
			q = {t[7:4], q[7:4]};
		end else
			i_host.xfer(s, r, d, q);
	endtask
	// Status polling until the engine is free
	task automatic poll;
		logic [7:0] q;
		int n;
		n = 0;
		do begin
			hx(1'b0, 1'b1, 8'h00, q);
			n++;
		end while (q[7] !== 1'b0 && n < 400);
		if (n >= 400) begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic put(input logic s, input logic [7:0] b);
		logic [7:0] q;
		hx(s, 1'b0, b, q);
		poll();
	endtask
	// Main sequence
	initial begin
		logic [7:0]  q;
		logic [7:0]  d [4];
		logic [6:0]  a;
		logic [31:0] w;
		int          n1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("occupied", 1, occ);
		poll();
		put(1'b0, 8'h01);
		put(1'b0, 8'h30);
		put(1'b0, 8'h06);
		put(1'b0, 8'h08);
		av(AV_MODE, 1'b0, 0, w);
		chk("mode", 32'h14, w);
		chk("rows", 16'h00FF, mask);
		chk("cursor row", 7, crow);
		av(4'hC, 1'b0, 0, w);
		chk("unmapped", 0, w);
		av(AV_CTRL, 1'b1, 0, w);
		av(AV_CTRL, 1'b0, 0, w);
		chk("ctrl off", 0, w);
		hx(1'b0, 1'b1, 8'h00, q);
		chk("port off", 8'hFF, q);
		av_be <= 4'h0;
		av(AV_CTRL, 1'b1, 1, w);
		av(AV_CTRL, 1'b0, 0, w);
		chk("ctrl masked", 0, w);
		av_be <= 4'hF;
		av(AV_CTRL, 1'b1, 1, w);
		av(AV_CTRL, 1'b0, 0, w);
		chk("ctrl", 1, w);
		put(1'b0, 8'h40);
		for (int k = 0; k < 16; k++)
			put(1'b1, 8'h1F);
		mon <= 1'b1;
		a = 7'({$random(seed)} % 36);
		put(1'b0, {1'b1, a});
		for (int k = 0; k < 4; k++) begin
			d[k] = 8'($random(seed));
			put(1'b1, d[k]);
		end
		hx(1'b0, 1'b1, 8'h00, q);
		chk("pointer", {1'b0, a + 7'd4}, q);
		chk("cursor", a + 7'd4, cadr);
		put(1'b0, {1'b1, a});
		for (int k = 0; k < 4; k++) begin
			hx(1'b1, 1'b1, 8'h00, q);
			poll();
			chk("data", d[k], q);
		end
		put(1'b0, 8'h10);
		put(1'b0, 8'h18);
		hx(1'b0, 1'b1, 8'h00, q);
		chk("shifted", {1'b0, a + 7'd3}, q);
		av(AV_MODE, 1'b0, 0, w);
		chk("offset", 1, w[14:8]);
		chk("offset pin", 1, shoff);
		put(1'b0, 8'h02);
		av(AV_MODE, 1'b0, 0, w);
		chk("home offset", 0, w[14:8]);
		chk("home pin", 0, shoff);
		put(1'b0, 8'h04);
		put(1'b0, 8'h0F);
		put(1'b0, 8'h85);
		put(1'b1, 8'h41);
		hx(1'b0, 1'b1, 8'h00, q);
		chk("decrement", 8'h04, q);
		av(AV_MODE, 1'b0, 0, w);
		chk("enables", 8'hE4, w[7:0]);
		chk("display on", 1, don);
		chk("cursor on", 1, con);
		n1 = 0;
		repeat (40) begin
			@(posedge clk);
			n1 += bdim;
		end
		chk("blink", 1, n1 > 0 && n1 < 40);
		put(1'b0, 8'h07);
		hx(1'b0, 1'b0, 8'h01, q);
		hx(1'b1, 1'b0, 8'h41, q);
		poll();
		av(AV_MODE, 1'b0, 0, w);
		chk("clear mode", 8'hEC, w[7:0]);
		spc <= 1'b1;
		repeat (8) @(posedge clk);
		spc <= 1'b0;
		put(1'b0, 8'h80);
		hx(1'b1, 1'b1, 8'h00, q);
		poll();
		chk("space", 8'h20, q);
		put(1'b1, 8'h41);
		av(AV_MODE, 1'b0, 0, w);
		chk("entry shift", 7'h4F, w[14:8]);
		put(1'b0, 8'h3C);
		chk("two rows", 16'hFFFF, mask);
		chk("two font", 7, crow);
		put(1'b0, 8'hA7);
		put(1'b0, 8'h14);
		hx(1'b0, 1'b1, 8'h00, q);
		chk("wrap", 8'h40, q);
		hx(1'b0, 1'b0, 8'h28, q);
		nib = 1'b1;
		poll();
		put(1'b0, 8'hC5);
		hx(1'b0, 1'b1, 8'h00, q);
		chk("nibbles", 8'h45, q);
		put(1'b0, 8'h24);
		chk("tall rows", 16'h07FF, mask);
		chk("tall cursor", 10, crow);
		finish_test();
	end
endmodule
`default_nettype wire
